// file: shared/sdcl_cfg.svh
// Constants of the synthesizer divider configuration loader
`ifndef SDCL_CFG_SVH
`define SDCL_CFG_SVH

// ---------------------------------------------------------------
// Serial stream layout
// ---------------------------------------------------------------
`define SDCL_SR_LEN 14
`define SDCL_T_W 3
`define SDCL_N_W 2
`define SDCL_M_W 9
`define SDCL_SR_MSB 13

// ---------------------------------------------------------------
// Diagnostic select codes
// ---------------------------------------------------------------
`define SDCL_TSEL_SHIFT 3'h0
`define SDCL_TSEL_ONE 3'h1
`define SDCL_TSEL_REF16 3'h2
`define SDCL_TSEL_FB 3'h3
`define SDCL_TSEL_FOUT 3'h4
`define SDCL_TSEL_ZERO 3'h5
`define SDCL_TSEL_BYPASS 3'h6
`define SDCL_TSEL_FOUT4 3'h7

// ---------------------------------------------------------------
// Divider constants
// ---------------------------------------------------------------
`define SDCL_DIV_W 4
`define SDCL_REF_HALF 4'h8
`define SDCL_FOUT4_HALF 4'h2
`define SDCL_POST_ONE 4'h1
`define SDCL_FB_ONE 9'h001
`define SDCL_FB_RST 9'h1FF
`define SDCL_N_RST 2'h3

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SDCL_AW 4
`define SDCL_OFF_CTRL 4'h0
`define SDCL_OFF_STAT 4'h4
`define SDCL_OFF_SHIFT 4'h8
`define SDCL_CTRL_RST 1'h1
`define SDCL_STAT_BYP 14
`define SDCL_STAT_PAR 15
`define SDCL_STAT_FB 16

`endif

// file: shared/sdcl_pkg.sv
// Types of the synthesizer divider configuration loader
package sdcl_pkg;

  // Divider configuration, laid out as the serial stream
  typedef struct packed {
    logic [2:0] test;
    logic [1:0] post;
    logic [8:0] fb;
  } sdcl_cfg_t;

endpackage

// file: hw/sdcl_tick_div.sv
// Tick divider: toggles its output every i_half input ticks
`timescale 1ns/1ps
`default_nettype none

module sdcl_tick_div #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic [W-1:0] i_half,
  output logic o_level
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic level_q;
  wire logic cnt_wrap;

  // -------------------------------------------------------------
  // Half period counter
  // -------------------------------------------------------------
  assign cnt_wrap = (W'(cnt_q + 1'b1) >= i_half);
  assign cnt_d = cnt_wrap ? '0 : W'(cnt_q + 1'b1);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else if (i_tick) begin
      cnt_q <= cnt_d;
      level_q <= level_q ^ cnt_wrap;
    end
  end

  assign o_level = level_q;

endmodule
`default_nettype wire

// file: hw/sdcl_top.sv
// Divider configuration loader of a clock synthesizer
// Operation
// - Load-strobe rising edge captures feedback and post pins
// - Strobe low: divider latches transparent to pins
// - Shift serial data on serial clock, fourteen bits
// - Stream order: diagnostic, post, feedback bits
// - Each field sent most significant bit first
// - Commit strobe falling edge loads shifted values
// - Diagnostic select settable only by serial stream
// - Strobe low forces diagnostic select to zero
// - Codes 000-011: shift out, one, ref/16, feedback
// - Codes 100-111: output, zero, bypass feedback, output/4
// - Shift register bits appear one per serial clock
// - Code 110 feeds serial clock into both dividers
// - Bypass: post divider drives output, feedback drives diagnostic
// - Bypass post code 00 (ratio one) halves serial clock rate
// - Bypass feedback output duty need not be even
// - Post code 01 selects division ratio two
// - Frequency step is reference/16 divided by post ratio
// - Post code maps to ratios one, two, four, eight
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "sdcl_cfg.svh"

module sdcl_top
  import sdcl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_par_load_n,
  input wire logic [8:0] i_fb_div_pins,
  input wire logic [1:0] i_post_sel_pins,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_ser_commit,
  input wire logic i_vco_tick,
  input wire logic i_ref_tick,
  input wire logic [`SDCL_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_synth_out,
  output logic o_diag,
  output sdcl_cfg_t o_cfg,
  output logic [3:0] o_post_ratio
);

  sdcl_cfg_t cfg_q;
  sdcl_cfg_t cfg_d;
  logic [`SDCL_SR_LEN-1:0] sr_q;
  logic [`SDCL_SR_LEN-1:0] sr_d;
  logic par_q;
  logic sclk_q;
  logic commit_q;
  logic [8:0] fb_cnt_q;
  logic [8:0] fb_cnt_d;
  logic diag_q;
  logic diag_d;
  logic run_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic fout4_q;

  // ---------------------------------------------------------------
  // Strobe and serial clock edges
  // ---------------------------------------------------------------
  wire logic par_rise;
  wire logic par_open;
  wire logic sclk_rise;
  wire logic commit_fall;
  wire logic ser_ok;
  wire logic do_shift;
  wire logic do_commit;

  assign par_rise = i_par_load_n & ~par_q;
  assign par_open = ~i_par_load_n;
  assign sclk_rise = i_ser_clk & ~sclk_q;
  assign commit_fall = ~i_ser_commit & commit_q;
  assign ser_ok = i_par_load_n & par_q;
  assign do_shift = sclk_rise & ser_ok;
  assign do_commit = commit_fall & ser_ok;

  // ---------------------------------------------------------------
  // Serial shift register
  // ---------------------------------------------------------------
  // MSB of each field enters first and ends at the top
  assign sr_d = {sr_q[`SDCL_SR_LEN-2:0], i_ser_data};

  // ---------------------------------------------------------------
  // Configuration selection, parallel path first
  // ---------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    if (par_open) begin
      cfg_d.fb = i_fb_div_pins;
      cfg_d.post = i_post_sel_pins;
      cfg_d.test = `SDCL_TSEL_SHIFT;
    end else if (par_rise) begin
      cfg_d.fb = i_fb_div_pins;
      cfg_d.post = i_post_sel_pins;
    end else if (do_commit) begin
      cfg_d = sdcl_cfg_t'(sr_q);
    end
  end

  // ---------------------------------------------------------------
  // Divider tick sources
  // ---------------------------------------------------------------
  wire logic bypass;
  wire logic div_tick;
  wire logic fb_wrap;
  wire logic fb_out;
  wire logic [3:0] post_half;
  wire logic post_level;
  wire logic ref16_level;
  wire logic fout_rise;
  wire logic fout4_level;

  assign bypass = (cfg_q.test == `SDCL_TSEL_BYPASS);
  assign div_tick = run_q & (bypass ? sclk_rise : i_vco_tick);
  // Post ratio 1, 2, 4, 8 from the two-bit code
  assign post_half = `SDCL_POST_ONE << cfg_q.post;

  // ---------------------------------------------------------------
  // Feedback counter
  // ---------------------------------------------------------------
  // Counts down from the unsigned ratio minus one; one tick of each period high
  assign fb_wrap = (fb_cnt_q == '0);
  assign fb_cnt_d = fb_wrap ? 9'(cfg_q.fb - `SDCL_FB_ONE)
                            : 9'(fb_cnt_q - `SDCL_FB_ONE);
  assign fb_out = fb_wrap;

  // ---------------------------------------------------------------
  // Post divider, reference and output dividers
  // ---------------------------------------------------------------
  // Post output period is twice the ratio in input ticks
  sdcl_tick_div #(
    .W(`SDCL_DIV_W)
  ) u_post_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(div_tick),
    .i_half(post_half),
    .o_level(post_level)
  );

  sdcl_tick_div #(
    .W(`SDCL_DIV_W)
  ) u_ref16_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(i_ref_tick),
    .i_half(`SDCL_REF_HALF),
    .o_level(ref16_level)
  );

  assign fout_rise = post_level & ~fout4_q;

  sdcl_tick_div #(
    .W(`SDCL_DIV_W)
  ) u_fout4_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(fout_rise),
    .i_half(`SDCL_FOUT4_HALF),
    .o_level(fout4_level)
  );

  // ---------------------------------------------------------------
  // Diagnostic output selection
  // ---------------------------------------------------------------
  always_comb begin
    case (cfg_q.test)
      `SDCL_TSEL_SHIFT: diag_d = sr_q[`SDCL_SR_MSB];
      `SDCL_TSEL_ONE: diag_d = 1'b1;
      `SDCL_TSEL_REF16: diag_d = ref16_level;
      `SDCL_TSEL_FB: diag_d = fb_out;
      `SDCL_TSEL_FOUT: diag_d = post_level;
      `SDCL_TSEL_ZERO: diag_d = 1'b0;
      `SDCL_TSEL_BYPASS: diag_d = fb_out;
      `SDCL_TSEL_FOUT4: diag_d = fout4_level;
      default: diag_d = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave, one wait state per access
  // ---------------------------------------------------------------
  wire logic req;
  wire logic wr_take;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic hit_shift;
  wire logic [31:0] stat_word;
  wire logic [31:0] rd_mux;

  assign req = i_avs_read | i_avs_write;
  assign wr_take = i_avs_write & ack_q;
  assign hit_ctrl = (i_avs_address == `SDCL_OFF_CTRL);
  assign hit_stat = (i_avs_address == `SDCL_OFF_STAT);
  assign hit_shift = (i_avs_address == `SDCL_OFF_SHIFT);
  assign stat_word = {7'h00, fb_cnt_q, i_par_load_n, bypass,
                      cfg_q};
  assign rd_mux = hit_ctrl ? {31'h0, run_q} :
                  hit_stat ? stat_word :
                  hit_shift ? {18'h0, sr_q} : 32'h0;
  assign o_avs_waitrequest = req & ~ack_q;

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      par_q <= 1'b0;
      sclk_q <= 1'b0;
      commit_q <= 1'b0;
      fout4_q <= 1'b0;
    end else begin
      par_q <= i_par_load_n;
      sclk_q <= i_ser_clk;
      commit_q <= i_ser_commit;
      fout4_q <= post_level;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_q <= '{test: `SDCL_TSEL_SHIFT, post: `SDCL_N_RST,
                 fb: `SDCL_FB_RST};
      sr_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      if (do_shift) begin
        sr_q <= sr_d;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fb_cnt_q <= '0;
      diag_q <= 1'b0;
    end else begin
      diag_q <= diag_d;
      if (div_tick) begin
        fb_cnt_q <= fb_cnt_d;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      run_q <= `SDCL_CTRL_RST;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (i_avs_read & ~ack_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_take & hit_ctrl & i_avs_byteenable[0]) begin
        run_q <= i_avs_writedata[0];
      end
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_synth_out = post_level;
  assign o_diag = diag_q;
  assign o_cfg = cfg_q;
  assign o_post_ratio = post_half;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_par_capture_pins: assert property (
    par_rise |=> (cfg_q.fb == $past(i_fb_div_pins)) &&
                 (cfg_q.post == $past(i_post_sel_pins)))
    else $error("parallel capture missed");

  a_par_transparent: assert property (
    par_open [*2] |-> (cfg_q.fb == $past(i_fb_div_pins)))
    else $error("latches not transparent");

  a_test_forced_zero: assert property (
    par_open |=> cfg_q.test == `SDCL_TSEL_SHIFT)
    else $error("test select not forced to zero");

  a_shift_one_bit: assert property (
    do_shift |=> sr_q == {$past(sr_q[`SDCL_SR_LEN-2:0]),
                          $past(i_ser_data)})
    else $error("shift register did not shift");

  a_shift_no_strobe: assert property (
    !do_shift |=> $stable(sr_q))
    else $error("shift without serial clock");

  a_commit_loads: assert property (
    do_commit |=> cfg_q == sdcl_cfg_t'($past(sr_q)))
    else $error("commit did not load shifted values");

  a_test_serial_only: assert property (
    !$past(do_commit) && !par_open |-> $stable(cfg_q.test))
    else $error("test select changed outside serial commit");

  a_diag_constants: assert property (
    (cfg_q.test == `SDCL_TSEL_ONE) |=> o_diag)
    else $error("diagnostic constant one wrong");

  a_diag_zero_const: assert property (
    (cfg_q.test == `SDCL_TSEL_ZERO) |=> !o_diag)
    else $error("diagnostic constant zero wrong");

  a_diag_shift_out: assert property (
    cfg_q.test == `SDCL_TSEL_SHIFT |=>
      o_diag == $past(sr_q[`SDCL_SR_MSB]))
    else $error("diagnostic not shift register out");

  a_fb_reload: assert property (
    div_tick && fb_wrap |=>
      fb_cnt_q == 9'($past(cfg_q.fb) - `SDCL_FB_ONE))
    else $error("feedback counter reload wrong");

  a_bypass_clock: assert property (
    bypass && run_q && !sclk_rise |=> $stable(fb_cnt_q))
    else $error("feedback counter moved without serial clock");

  a_post_toggle: assert property (
    $changed(post_level) |-> $past(div_tick))
    else $error("post divider toggled without tick");

  c_par_load: cover property (par_open ##1 par_rise);
  c_commit: cover property (do_commit ##1 bypass);
  c_shift_full: cover property (do_shift ##[1:40] do_commit);
  c_bus_read: cover property (i_avs_read && ack_q && hit_stat);

endmodule
`default_nettype wire

// file: dv/sdcl_host_model.sv
// Host model driving the parallel pins and the serial wires
`timescale 1ns/1ps
`default_nettype none

module sdcl_host_model #(
  parameter int HALF = 5
) (
  input wire logic i_clk,
  output logic o_par_load_n,
  output logic [8:0] o_fb,
  output logic [1:0] o_post,
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_ser_commit
);
  initial begin
    o_par_load_n = 1'b0;
    o_fb = 9'h1FF;
    o_post = 2'h3;
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_commit = 1'b0;
  end

  // Parallel pins and strobe
  task automatic par(input logic ld_n, input logic [8:0] fb,
                     input logic [1:0] post);
    o_par_load_n <= ld_n;
    o_fb <= fb;
    o_post <= post;
    repeat (2) @(posedge i_clk);
  endtask

  // One serial bit; clock stays low between bits
  task automatic ser_bit(input logic b);
    o_ser_data <= b;
    repeat (HALF) @(posedge i_clk);
    o_ser_clk <= 1'b1;
    repeat (HALF) @(posedge i_clk);
    o_ser_clk <= 1'b0;
    o_ser_data <= ~b;
    @(posedge i_clk);
  endtask

  // Whole stream, each field most significant bit first
  task automatic ser_word(input logic [13:0] w);
    for (int i = 13; i >= 0; i--) ser_bit(w[i]);
  endtask

  // Commit pulse after the register is full
  task automatic commit();
    o_ser_commit <= 1'b1;
    repeat (HALF) @(posedge i_clk);
    o_ser_commit <= 1'b0;
    repeat (HALF) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// file: dv/synth_divider_config_loader_tb.sv
// Self-checking bench of the divider configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "sdcl_cfg.svh"

module synth_divider_config_loader_tb
  import sdcl_pkg::*;
;
  typedef struct packed {
    logic [8:0] fb;
    logic [1:0] post;
    logic [3:0] ratio;
  } sdcl_row_t;
  sdcl_row_t rows [4] = '{'{9'h106, 2'h1, 4'h2}, '{9'h0C8, 2'h0, 4'h1},
                         '{9'h190, 2'h2, 4'h4}, '{9'h1FF, 2'h3, 4'h8}};
  logic i_clk, i_rst, vco_tick, ref_tick, vco_en, syn_q, dia_q;
  logic par_n, s_clk, s_dat, s_com;
  logic [8:0] fb;
  logic [1:0] post;
  logic [3:0] adr;
  logic rd_s, wr_s;
  logic [31:0] wd, rdv, o_avs_readdata;
  logic o_avs_waitrequest, o_synth_out, o_diag;
  logic [3:0] o_post_ratio;
  logic [13:0] w;
  sdcl_cfg_t o_cfg;
  int n_errors = 0, checks = 0, cyc = 0, tog = 0, drise = 0, t0, d0;

  sdcl_host_model HOST (.i_clk(i_clk), .o_par_load_n(par_n), .o_fb(fb),
    .o_post(post), .o_ser_clk(s_clk), .o_ser_data(s_dat),
    .o_ser_commit(s_com));

  sdcl_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_par_load_n(par_n),
    .i_fb_div_pins(fb), .i_post_sel_pins(post), .i_ser_clk(s_clk),
    .i_ser_data(s_dat), .i_ser_commit(s_com), .i_vco_tick(vco_tick),
    .i_ref_tick(ref_tick), .i_avs_address(adr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_synth_out(o_synth_out), .o_diag(o_diag), .o_cfg(o_cfg),
    .o_post_ratio(o_post_ratio));

  // ----------------------------------------------------------------
  // Clock, ticks, edge counters and timeout
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    syn_q <= o_synth_out;
    dia_q <= o_diag;
    if (o_synth_out !== syn_q) tog <= tog + 1;
    if (o_diag === 1'b1 && dia_q === 1'b0) drise <= drise + 1;
    vco_tick <= vco_en & ~vco_tick;
    ref_tick <= ~ref_tick;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr_s <= wr;
    rd_s <= ~wr;
    // Hold the request until waitrequest is sampled low at a rising edge
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rdv = o_avs_readdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    vco_tick = 1'b0;
    ref_tick = 1'b0;
    vco_en = 1'b1;
    adr = 4'h0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    wd = 32'h0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    check("cfg_rst", o_cfg, 14'h07FF);
    check("ratio_rst", o_post_ratio, 4'h8);
    av(1'b0, `SDCL_OFF_CTRL, 32'h0);
    check("ctrl_rst", rdv, 32'h1);
    av(1'b1, `SDCL_OFF_CTRL, 32'h0);
    av(1'b0, `SDCL_OFF_CTRL, 32'h0);
    check("ctrl_wr", rdv, 32'h0);
    av(1'b1, `SDCL_OFF_CTRL, 32'h1);
    av(1'b0, 4'hC, 32'h0);
    check("unmapped", rdv, 32'h0);
    HOST.par(1'b1, 9'h1FF, 2'h3);
    for (int c = 0; c < 8; c++) begin
      w = {c[2:0], 2'h1, 9'h106};
      HOST.ser_word(w);
      HOST.commit();
      check("cfg_ser", o_cfg, w);
      if (c == 1 || c == 5) check("diag_const", o_diag, c == 1);
    end
    check("ratio_ser", o_post_ratio, 4'h2);
    HOST.par(1'b0, 9'h0C8, 2'h0);
    HOST.ser_word(14'h0000);
    check("cfg_refuse", o_cfg, 14'h00C8);
    av(1'b0, `SDCL_OFF_SHIFT, 32'h0);
    check("shift_refuse", rdv[13:0], w);
    foreach (rows[i]) begin
      HOST.par(1'b0, rows[i].fb, rows[i].post);
      check("cfg_transp", o_cfg, {3'h0, rows[i].post, rows[i].fb});
      check("ratio_par", o_post_ratio, rows[i].ratio);
      HOST.par(1'b1, rows[i].fb, rows[i].post);
      HOST.par(1'b1, ~rows[i].fb, ~rows[i].post);
      check("cfg_capt", o_cfg, {3'h0, rows[i].post, rows[i].fb});
      av(1'b0, `SDCL_OFF_STAT, 32'h0);
      check("stat", rdv[15:0], {5'h10, rows[i].post, rows[i].fb});
    end
    HOST.ser_word(14'h04C8);
    HOST.commit();
    check("diag_sr0", o_diag, 1'b0);
    repeat (3) HOST.ser_bit(1'b0);
    check("diag_sr3", o_diag, 1'b1);
    HOST.ser_word({3'h6, 2'h0, 9'h004});
    HOST.commit();
    vco_en <= 1'b0;
    av(1'b1, `SDCL_OFF_CTRL, 32'h0);
    av(1'b1, `SDCL_OFF_CTRL, 32'h1);
    av(1'b0, `SDCL_OFF_STAT, 32'h0);
    check("bypass", rdv[14], 1'b1);
    t0 = tog;
    d0 = drise;
    repeat (8) HOST.ser_bit(1'b0);
    repeat (4) @(posedge i_clk);
    check("byp_fout", tog - t0, 8);
    // Enough further ticks for the feedback counter to reach zero
    repeat (rdv[24:16]) HOST.ser_bit(1'b0);
    repeat (4) @(posedge i_clk);
    check("byp_diag", drise != d0, 1'b1);
    finish_test();
  end
endmodule

`default_nettype wire
